// file: verilog/csr_pkg.sv
// constants shared by the counter and shift register block
// assumes a 32-bit classic wishbone host addressing aligned words
package csr_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int CSR_ADR_W = 18;
    localparam int CSR_DAT_W = 32;
    localparam int CSR_SEL_W = 4;
    localparam int CSR_IDX_W = 16;
    localparam int CSR_IDX_LSB = 2;
    localparam int CSR_WORD_W = 16;

    typedef logic [CSR_IDX_W-1:0] csr_idx_t;
    typedef logic [CSR_WORD_W-1:0] csr_word_t;

    // ------------------------------------------------------------
    // counter ranges
    // ------------------------------------------------------------
    localparam int CSR_STAGE_W = 14;
    localparam int CSR_UD_W = 27;

    typedef logic [CSR_STAGE_W-1:0] csr_stage_t;
    typedef logic [CSR_UD_W-1:0] csr_ud_t;

    localparam csr_stage_t CSR_STAGE_MAX = 14'h270F;
    localparam csr_stage_t CSR_STAGE_ONE = 14'h0001;
    localparam csr_stage_t CSR_STAGE_ZERO = 14'h0000;
    localparam csr_ud_t CSR_UD_MAX = 27'h5F5E0FF;
    localparam csr_ud_t CSR_UD_ONE = 27'h0000001;
    localparam csr_ud_t CSR_UD_ZERO = 27'h0000000;

    // ------------------------------------------------------------
    // register map, word indices (byte address is index times four)
    // ------------------------------------------------------------
    localparam csr_idx_t CSR_IDX_STATUS = 16'h0000;
    localparam csr_idx_t CSR_IDX_STAGE_PRESET = 16'h0001;
    localparam csr_idx_t CSR_IDX_UD_PRESET_LO = 16'h0002;
    localparam csr_idx_t CSR_IDX_UD_PRESET_HI = 16'h0003;
    localparam csr_idx_t CSR_IDX_SHIFT_BASE = 16'h0010;
    localparam csr_idx_t CSR_VALUE_BASE = 16'h03E8;

    // status word bit positions
    localparam int CSR_ST_STAGE = 0;
    localparam int CSR_ST_UD = 1;

    // preset reset values equal each counter's maximum, so a flag comes on only at full count until programmed
    localparam csr_word_t CSR_STAGE_PRESET_RST = 16'h270F;
    localparam logic [2*CSR_WORD_W-1:0] CSR_UD_PRESET_RST = 32'h05F5E0FF;

endpackage : csr_pkg

// file: verilog/csr_shift_register.sv
// bit shifter over a byte-aligned block of relays
// assumes shiftStep is already a one-scan edge pulse on the same clock
`timescale 1ns/100ps

module csr_shift_register #(
    parameter int WIDTH = 16,
    parameter bit ASCEND = 1'b1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // shift controls
    input wire logic shiftData,
    input wire logic shiftStep,
    input wire logic shiftClear,
    // block contents
    output logic [WIDTH-1:0] bits
);
    import csr_pkg::*;

    // ------------------------------------------------------------
    // shift path
    // ------------------------------------------------------------
    localparam int START = ASCEND ? 0 : WIDTH - 1;

    logic [WIDTH-1:0] shifted;
    logic [WIDTH-1:0] next_bits;

    // start bit takes the data, the rest move away from it
    assign shifted = ASCEND ? {bits[WIDTH-2:0], shiftData}
                            : {shiftData, bits[WIDTH-1:1]};
    // clear wins so a reset scan never leaves a stray bit
    assign next_bits = shiftClear ? '0 : (shiftStep ? shifted : bits);

    // block storage
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bits <= '0;
        end else begin
            bits <= next_bits;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_shift_move;
        @(posedge clock) disable iff (!rst_n)
        shiftStep && !shiftClear |=> bits[START] == $past(shiftData)
            && (ASCEND ? bits[WIDTH-1:1] == $past(bits[WIDTH-2:0])
                       : bits[WIDTH-2:0] == $past(bits[WIDTH-1:1]));
    endproperty
    a_shift_move: assert property (p_shift_move) else $error("shift step wrong");

    property p_shift_clear;
        @(posedge clock) disable iff (!rst_n)
        shiftClear |=> bits == '0;
    endproperty
    a_shift_clear: assert property (p_shift_clear) else $error("shift clear failed");

endmodule : csr_shift_register

// file: verilog/csr_counters.sv
// hold counter, bidirectional counter and bit shifter, one scan per clock
// assumes ladder inputs are driven from logic on the same clock
// assumes a classic wishbone master for presets, values and status
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps

// Overview of operation
// - hold counter adds one on each off-to-on change of its count input.
// - hold counter keeps its value until its own reset command.
// - hold counter counts past preset, stops at 9999 and holds there.
// - hold counter flag is on while value is at or above preset.
// - each counter value sits at word counter number plus 1000.
// - hold counter reset clears value to zero and drops flag.
// - bidirectional counter counts up on up edges, down on down edges.
// - bidirectional counter is zero for as long as its reset is on.
// - bidirectional counter spans zero to 99999999, eight digits.
// - eight-digit count uses two words and two counter numbers.
// - bidirectional counter flag is on while count is at or above preset.
// - each shift clock edge moves the block and loads data at start.
// - start below end shifts upward, otherwise downward.
// - shifter reset clears every bit of the block.
module csr_counters #(
    parameter int STAGE_NUM = 7,
    parameter int UD_NUM = 2,
    parameter int SHIFT_FROM = 0,
    parameter int SHIFT_TO = 15
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [csr_pkg::CSR_ADR_W-1:0] wb_adr_i,
    input wire logic [csr_pkg::CSR_SEL_W-1:0] wb_sel_i,
    input wire logic [csr_pkg::CSR_DAT_W-1:0] wb_dat_i,
    output logic [csr_pkg::CSR_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // hold counter inputs and state
    input wire logic stageCount,
    input wire logic stageReset,
    output csr_pkg::csr_stage_t stageValue,
    output logic stageFlag,
    // bidirectional counter inputs and state
    input wire logic udUp,
    input wire logic udDown,
    input wire logic udReset,
    output csr_pkg::csr_ud_t udValue,
    output logic udFlag,
    // bit shifter inputs and state
    input wire logic shiftData,
    input wire logic shiftClock,
    input wire logic shiftReset,
    output logic [(SHIFT_FROM < SHIFT_TO ? SHIFT_TO - SHIFT_FROM
                   : SHIFT_FROM - SHIFT_TO):0] shiftBits
);
    import csr_pkg::*;

    // ------------------------------------------------------------
    // derived geometry
    // ------------------------------------------------------------
    // block size and alignment are the program's duty; not policed here
    localparam bit SHIFT_ASCEND = SHIFT_FROM < SHIFT_TO;
    localparam int SHIFT_W = SHIFT_ASCEND ? SHIFT_TO - SHIFT_FROM + 1
                                          : SHIFT_FROM - SHIFT_TO + 1;
    localparam int SHIFT_WORDS = (SHIFT_W + CSR_WORD_W - 1) / CSR_WORD_W;
    localparam int SHIFT_PAD_W = SHIFT_WORDS * CSR_WORD_W;
    localparam csr_idx_t STAGE_VAL_IDX = CSR_VALUE_BASE + csr_idx_t'(STAGE_NUM);
    localparam csr_idx_t UD_VAL_LO_IDX = CSR_VALUE_BASE + csr_idx_t'(UD_NUM);
    localparam csr_idx_t UD_VAL_HI_IDX = CSR_VALUE_BASE + csr_idx_t'(UD_NUM + 1);
    localparam csr_idx_t SHIFT_END_IDX = CSR_IDX_SHIFT_BASE + csr_idx_t'(SHIFT_WORDS);

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic stagePrev;
    logic upPrev;
    logic downPrev;
    logic shiftPrev;
    logic stageEdge;
    logic upEdge;
    logic downEdge;
    logic shiftEdge;
    logic upCount;
    logic downCount;

    // one level compare per scan gives at most one edge per input
    assign stageEdge = stageCount && !stagePrev;
    assign upEdge = udUp && !upPrev;
    assign downEdge = udDown && !downPrev;
    assign shiftEdge = shiftClock && !shiftPrev;
    // a busy opposite input blocks the count
    assign upCount = upEdge && !udDown;
    assign downCount = downEdge && !udUp;

    // previous scan levels
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stagePrev <= 1'b0;
            upPrev <= 1'b0;
            downPrev <= 1'b0;
            shiftPrev <= 1'b0;
        end else begin
            stagePrev <= stageCount;
            upPrev <= udUp;
            downPrev <= udDown;
            shiftPrev <= shiftClock;
        end
    end

    // ------------------------------------------------------------
    // hold counter
    // ------------------------------------------------------------
    csr_word_t stagePreset;
    csr_stage_t next_stageValue;
    logic next_stageFlag;

    // reset command first, else count and saturate, else hold
    always_comb begin
        next_stageValue = stageValue;
        if (stageReset) begin
            next_stageValue = CSR_STAGE_ZERO;
        end else if (stageEdge && stageValue != CSR_STAGE_MAX) begin
            next_stageValue = stageValue + CSR_STAGE_ONE;
        end
    end

    // flag follows the new value; a reset scan forces it off
    assign next_stageFlag = !stageReset
        && CSR_WORD_W'(next_stageValue) >= stagePreset;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stageValue <= CSR_STAGE_ZERO;
            stageFlag <= 1'b0;
        end else begin
            stageValue <= next_stageValue;
            stageFlag <= next_stageFlag;
        end
    end

    // ------------------------------------------------------------
    // bidirectional counter
    // ------------------------------------------------------------
    csr_word_t udPresetLo;
    csr_word_t udPresetHi;
    csr_ud_t next_udValue;
    logic next_udFlag;

    // level reset dominates; ends of range hold instead of wrapping
    always_comb begin
        next_udValue = udValue;
        if (udReset) begin
            next_udValue = CSR_UD_ZERO;
        end else if (upCount && udValue != CSR_UD_MAX) begin
            next_udValue = udValue + CSR_UD_ONE;
        end else if (downCount && udValue != CSR_UD_ZERO) begin
            next_udValue = udValue - CSR_UD_ONE;
        end
    end

    assign next_udFlag = !udReset
        && (2 * CSR_WORD_W)'(next_udValue) >= {udPresetHi, udPresetLo};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            udValue <= CSR_UD_ZERO;
            udFlag <= 1'b0;
        end else begin
            udValue <= next_udValue;
            udFlag <= next_udFlag;
        end
    end

    // ------------------------------------------------------------
    // bit shifter
    // ------------------------------------------------------------
    csr_shift_register #(
        .WIDTH(SHIFT_W),
        .ASCEND(SHIFT_ASCEND)
    ) u_shifter (
        .clock(clock),
        .rst_n(rst_n),
        .shiftData(shiftData),
        .shiftStep(shiftEdge),
        .shiftClear(shiftReset),
        .bits(shiftBits)
    );

    // ------------------------------------------------------------
    // wishbone decode
    // ------------------------------------------------------------
    csr_idx_t idx;
    csr_idx_t shiftOff;
    csr_word_t statusWord;
    csr_word_t shiftWord;
    csr_word_t rdWord;
    logic [SHIFT_PAD_W-1:0] shiftPad;
    logic wbReq;
    logic wrTake;
    logic hitShift;

    assign wbReq = wb_cyc_i && wb_stb_i;
    // writes land on the edge where the master sees ack
    assign wrTake = wbReq && wb_we_i && wb_ack_o;
    assign idx = wb_adr_i[CSR_IDX_LSB +: CSR_IDX_W];
    assign hitShift = idx >= CSR_IDX_SHIFT_BASE && idx < SHIFT_END_IDX;
    assign shiftOff = hitShift ? idx - CSR_IDX_SHIFT_BASE : '0;
    assign shiftPad = SHIFT_PAD_W'(shiftBits);
    assign shiftWord = shiftPad[shiftOff * CSR_WORD_W +: CSR_WORD_W];
    assign statusWord = (CSR_WORD_W'(stageFlag) << CSR_ST_STAGE)
        | (CSR_WORD_W'(udFlag) << CSR_ST_UD);

    // read select; unmapped words read as zero
    assign rdWord = (idx == CSR_IDX_STATUS) ? statusWord
        : (idx == CSR_IDX_STAGE_PRESET) ? stagePreset
        : (idx == CSR_IDX_UD_PRESET_LO) ? udPresetLo
        : (idx == CSR_IDX_UD_PRESET_HI) ? udPresetHi
        : (idx == STAGE_VAL_IDX) ? CSR_WORD_W'(stageValue)
        : (idx == UD_VAL_LO_IDX) ? udValue[CSR_WORD_W-1:0]
        : (idx == UD_VAL_HI_IDX) ? CSR_WORD_W'(udValue[CSR_UD_W-1:CSR_WORD_W])
        : hitShift ? shiftWord
        : '0;

    // byte-lane merge for the 16-bit preset words
    function automatic csr_word_t mergeWord(csr_word_t old, csr_word_t dat,
                                            logic [1:0] sel);
        mergeWord = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction : mergeWord

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wbReq && !wb_ack_o;
            wb_dat_o <= CSR_DAT_W'(rdWord);
        end
    end

    // preset registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stagePreset <= CSR_STAGE_PRESET_RST;
            udPresetLo <= CSR_UD_PRESET_RST[CSR_WORD_W-1:0];
            udPresetHi <= CSR_UD_PRESET_RST[2*CSR_WORD_W-1:CSR_WORD_W];
        end else if (wrTake) begin
            if (idx == CSR_IDX_STAGE_PRESET) begin
                stagePreset <= mergeWord(stagePreset, wb_dat_i[15:0], wb_sel_i[1:0]);
            end
            if (idx == CSR_IDX_UD_PRESET_LO) begin
                udPresetLo <= mergeWord(udPresetLo, wb_dat_i[15:0], wb_sel_i[1:0]);
            end
            if (idx == CSR_IDX_UD_PRESET_HI) begin
                udPresetHi <= mergeWord(udPresetHi, wb_dat_i[15:0], wb_sel_i[1:0]);
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_stage_count;
        @(posedge clock) disable iff (!rst_n)
        stageEdge && !stageReset && stageValue < CSR_STAGE_MAX
            |=> stageValue == $past(stageValue) + CSR_STAGE_ONE;
    endproperty
    a_stage_count: assert property (p_stage_count) else $error("hold count missed");

    property p_stage_hold;
        @(posedge clock) disable iff (!rst_n)
        !stageCount && !stageReset |=> $stable(stageValue);
    endproperty
    a_stage_hold: assert property (p_stage_hold) else $error("hold value moved");

    property p_stage_sat;
        @(posedge clock) disable iff (!rst_n)
        stageValue == CSR_STAGE_MAX && !stageReset |=> stageValue == CSR_STAGE_MAX;
    endproperty
    a_stage_sat: assert property (p_stage_sat) else $error("hold counter wrapped");

    property p_stage_flag;
        @(posedge clock) disable iff (!rst_n)
        !stageReset |=> stageFlag == (CSR_WORD_W'(stageValue) >= $past(stagePreset));
    endproperty
    a_stage_flag: assert property (p_stage_flag) else $error("hold flag wrong");

    property p_stage_reset;
        @(posedge clock) disable iff (!rst_n)
        stageReset |=> stageValue == CSR_STAGE_ZERO && !stageFlag;
    endproperty
    a_stage_reset: assert property (p_stage_reset) else $error("hold reset failed");

    property p_ud_up;
        @(posedge clock) disable iff (!rst_n)
        udUp && !upPrev && !udDown && !udReset && udValue < CSR_UD_MAX
            |=> udValue == $past(udValue) + CSR_UD_ONE;
    endproperty
    a_ud_up: assert property (p_ud_up) else $error("up count missed");

    property p_ud_reset;
        @(posedge clock) disable iff (!rst_n)
        udReset [*2] |-> udValue == CSR_UD_ZERO && !udFlag;
    endproperty
    a_ud_reset: assert property (p_ud_reset) else $error("level reset failed");

    property p_ud_range;
        @(posedge clock) disable iff (!rst_n)
        udValue <= CSR_UD_MAX;
    endproperty
    a_ud_range: assert property (p_ud_range) else $error("count out of range");

    property p_ud_floor;
        @(posedge clock) disable iff (!rst_n)
        downEdge && udValue == CSR_UD_ZERO && !udReset |=> udValue == CSR_UD_ZERO;
    endproperty
    a_ud_floor: assert property (p_ud_floor) else $error("count went below zero");

    property p_ud_flag;
        @(posedge clock) disable iff (!rst_n)
        !udReset |=> udFlag
            == ((2 * CSR_WORD_W)'(udValue) >= $past({udPresetHi, udPresetLo}));
    endproperty
    a_ud_flag: assert property (p_ud_flag) else $error("count flag wrong");

endmodule : csr_counters

// file: sim/csr_ladder.sv
// ladder program model: drives count, reset and shift inputs scan by scan
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/100ps

module csr_ladder (
    // scan clock
    input wire logic clock,
    // ladder outputs
    output logic stageCount,
    output logic stageReset,
    output logic udUp,
    output logic udDown,
    output logic udReset,
    output logic shiftData,
    output logic shiftClock,
    output logic shiftReset
);
    // --------------------------------------------------------------
    // line levels, all off at power up
    // --------------------------------------------------------------
    logic [7:0] lines = 8'h00;
    assign {shiftReset, shiftClock, shiftData, udReset, udDown, udUp, stageReset,
            stageCount} = lines;

    // one level change, seen by the block at the next scan
    task automatic setLevel(input int k, input logic v);
        lines[k] <= v;
        @(posedge clock);
    endtask : setLevel

    // one scan on, one scan off: a fresh edge each time, other count line untouched
    task automatic pulse(input int k);
        setLevel(k, 1'b1);
        setLevel(k, 1'b0);
    endtask : pulse
endmodule : csr_ladder

// file: sim/counters_and_shift_register_bench.sv
// self-checking bench for the counters and shift register block
// assumes csr_pkg is compiled first and the ladder model drives all scan inputs
`timescale 1ns/100ps

module counters_and_shift_register_bench;
    import csr_pkg::*;
    // --------------------------------------------------------------
    // clock, reset, bus and ladder signals
    // --------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [CSR_ADR_W-1:0] wbAdr = 18'h00000;
    logic [CSR_SEL_W-1:0] wbSel = 4'h0;
    logic [CSR_DAT_W-1:0] wbDatW = 32'h00000000;
    logic [CSR_DAT_W-1:0] wbDatR;
    logic wbAck;
    logic stageCount, stageReset, udUp, udDown, udReset, shiftData, shiftClock, stageFlag;
    logic udFlag, shiftReset;
    csr_stage_t stageValue;
    csr_ud_t udValue;
    logic [15:0] shiftBits;
    logic [7:0] downBits;
    int n_mismatch = 0;
    int checks = 0;

    always #5 clock = ~clock;

    // --------------------------------------------------------------
    // block under test, far side and a descending shifter
    // --------------------------------------------------------------
    // byte aligned 0..15 block, sixteen relays long
    csr_counters #(.STAGE_NUM(7), .UD_NUM(2), .SHIFT_FROM(0), .SHIFT_TO(15)) dut (
        .clock(clock), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .stageCount(stageCount), .stageReset(stageReset),
        .stageValue(stageValue), .stageFlag(stageFlag), .udUp(udUp), .udDown(udDown),
        .udReset(udReset), .udValue(udValue), .udFlag(udFlag), .shiftData(shiftData),
        .shiftClock(shiftClock), .shiftReset(shiftReset), .shiftBits(shiftBits));
    // same block with start above end, relays 7..0: exercises the descending path
    csr_counters #(.STAGE_NUM(7), .UD_NUM(2), .SHIFT_FROM(7), .SHIFT_TO(0)) dutDown (
        .clock(clock), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(),
        .wb_ack_o(), .stageCount(stageCount), .stageReset(stageReset),
        .stageValue(), .stageFlag(), .udUp(udUp), .udDown(udDown),
        .udReset(udReset), .udValue(), .udFlag(), .shiftData(shiftData),
        .shiftClock(shiftClock), .shiftReset(shiftReset), .shiftBits(downBits));
    csr_ladder ladder (.clock(clock), .stageCount(stageCount), .stageReset(stageReset),
        .udUp(udUp), .udDown(udDown), .udReset(udReset), .shiftData(shiftData),
        .shiftClock(shiftClock), .shiftReset(shiftReset));

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // classic single cycle; held until ack is sampled, then one idle cycle
    task automatic wbXfer(input logic we, input logic [15:0] idx, input logic [15:0] wd,
                          input logic [3:0] sel, output logic [31:0] rd);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'h0};
        wbSel <= sel;
        wbDatW <= {16'h0000, wd};
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clock);
        if (n >= 20) begin
            n_mismatch++;
            summarize();
        end
    endtask : wbXfer

    task automatic rdCheck(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        wbXfer(1'b0, idx, 16'h0000, 4'h3, rd);
        check(rd, exp);
    endtask : rdCheck

    task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
        logic [31:0] rd;
        wbXfer(1'b1, idx, wd, 4'h3, rd);
    endtask : wr

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    // reset values, read-only places and an unmapped word
    task automatic testRegisters();
        logic [31:0] rd;
        rdCheck(16'h0001, 32'h0000270F);
        rdCheck(16'h0002, 32'h0000E0FF);
        rdCheck(16'h0003, 32'h000005F5);
        rdCheck(16'h0000, 32'h00000000);
        wr(16'h0000, 16'hFFFF);
        wr(16'h03EF, 16'h0005);
        wr(16'h0100, 16'h1234);
        rdCheck(16'h0000, 32'h00000000);
        rdCheck(16'h03EF, 32'h00000000);
        rdCheck(16'h0100, 32'h00000000);
        // low lane only: the high byte of the preset must survive
        wbXfer(1'b1, 16'h0001, 16'hAB12, 4'h1, rd);
        rdCheck(16'h0001, 32'h00002712);
        $display("test registers done");
    endtask : testRegisters

    task automatic testStage();
        wr(16'h0001, 16'h0003);
        ladder.pulse(0);
        ladder.pulse(0);
        check(32'(stageValue), 32'h00000002);
        check(32'(stageFlag), 32'h00000000);
        ladder.pulse(0);
        check(32'(stageFlag), 32'h00000001);
        ladder.setLevel(0, 1'b1);
        repeat (4) @(posedge clock);
        ladder.setLevel(0, 1'b0);
        repeat (6) @(posedge clock);
        check(32'(stageValue), 32'h00000004);
        rdCheck(16'h03EF, 32'h00000004);
        rdCheck(16'h0000, 32'h00000001);
        repeat (10001) ladder.pulse(0);
        check(32'(stageValue), 32'h0000270F);
        check(32'(stageFlag), 32'h00000001);
        ladder.pulse(1);
        check(32'(stageValue), 32'h00000000);
        check(32'(stageFlag), 32'h00000000);
        $display("test stage done");
    endtask : testStage

    task automatic testUpDown();
        wr(16'h0002, 16'h0005);
        wr(16'h0003, 16'h0000);
        repeat (5) ladder.pulse(2);
        check(32'(udFlag), 32'h00000001);
        rdCheck(16'h03EA, 32'h00000005);
        rdCheck(16'h03EB, 32'h00000000);
        rdCheck(16'h0000, 32'h00000002);
        ladder.pulse(3);
        check(32'(udValue), 32'h00000004);
        check(32'(udFlag), 32'h00000000);
        ladder.setLevel(3, 1'b1);
        ladder.pulse(2);
        ladder.setLevel(3, 1'b0);
        check(32'(udValue), 32'h00000003);
        ladder.setLevel(4, 1'b1);
        ladder.pulse(2);
        ladder.pulse(2);
        check(32'(udValue), 32'h00000000);
        ladder.setLevel(4, 1'b0);
        ladder.pulse(3);
        check(32'(udValue), 32'h00000000);
        $display("test up down done");
    endtask : testUpDown

    task automatic testShift();
        logic [15:0] expUp;
        logic [7:0] expDown;
        logic [9:0] pat;
        expUp = 16'h0000;
        expDown = 8'h00;
        pat = 10'h2D3;
        for (int i = 0; i < 10; i++) begin
            ladder.setLevel(5, pat[i]);
            ladder.pulse(6);
            expUp = {expUp[14:0], pat[i]};
            expDown = {pat[i], expDown[7:1]};
        end
        check(32'(shiftBits), 32'(expUp));
        check(32'(downBits), 32'(expDown));
        rdCheck(16'h0010, 32'(expUp));
        ladder.setLevel(7, 1'b1);
        ladder.setLevel(7, 1'b0);
        check(32'(shiftBits), 32'h00000000);
        check(32'(downBits), 32'h00000000);
        $display("test shift done");
    endtask : testShift

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        testRegisters();
        testStage();
        testUpDown();
        testShift();
        summarize();
    end
endmodule : counters_and_shift_register_bench
